// *** shared/msdec_pkg.sv ***
package msdec_pkg;
    // ====================================================
    // address spaces and boundaries
    localparam logic [16:0] MSDEC_ROM_BYTES = 17'h0_2000;   // 8 Kbyte on-chip program memory
    localparam logic [15:0] MSDEC_ON_CHIP_EXTENDED_RAM_BYTES = 16'h0100;    // extended ram size
    localparam logic [15:0] MSDEC_ON_CHIP_EXTENDED_RAM_BASE = 16'hFF00;     // top of external data space
    localparam logic [7:0] MSDEC_UPPER_BASE = 8'h80;        // first address above lower ram
    localparam logic [7:0] MSDEC_BITRAM_BASE = 8'h20;       // first bit-addressable byte
    localparam logic [7:0] MSDEC_BANK_TOP = 8'h1F;          // last register bank byte
    // ====================================================
    // registers
    localparam logic [7:0] MSDEC_SYSCTL_ADDR = 8'hB1;       // system_control
    localparam logic [7:0] MSDEC_PSW_ADDR = 8'hD0;          // processor_status_word
    localparam logic [7:0] MSDEC_ACC_ADDR = 8'hE0;          // accumulator
    localparam logic [7:0] MSDEC_SYSCTL_RESET = 8'h00;
    localparam int MSDEC_REGISTER_MAP_SELECT_BIT = 4;                      // register_map_select position
    localparam int MSDEC_BANK_LO_BIT = 3;                   // bank_select_low in status word
    localparam int MSDEC_BANK_HI_BIT = 4;                   // bank_select_high in status word
    // ====================================================
    // access kinds requested by the core
    typedef enum logic [2:0] {
        MSDEC_ACC_NONE,
        MSDEC_ACC_DIRECT,
        MSDEC_ACC_INDIRECT,
        MSDEC_ACC_REGISTER,
        MSDEC_ACC_BIT,
        MSDEC_ACC_XMOVE_DATA_POINTER_16,
        MSDEC_ACC_XMOVE_REG
    } msdec_kind_e;
    // resulting target space
    typedef enum logic [2:0] {
        MSDEC_TGT_NONE,
        MSDEC_TGT_LOWER_RAM,
        MSDEC_TGT_UPPER_RAM,
        MSDEC_TGT_SFR_STD,
        MSDEC_TGT_SFR_MAPPED,
        MSDEC_TGT_ON_CHIP_EXTENDED_RAM,
        MSDEC_TGT_EXT_DATA
    } msdec_tgt_e;
endpackage

// *** design/msdec_decoder.sv ***
`timescale 1ns/1ps
// Functional notes
// RULE_01: external access select low forces every fetch to external program memory.
// RULE_02: select high fetches on-chip, external only above the on-chip limit.
// RULE_03: select high returns fetches on-chip once address drops below limit.
// RULE_04: on-chip program boundary is a variant parameter, 8 Kbyte here.
// RULE_05: internal data uses 8-bit addresses; external and extended ram 8 or 16; here extended ram is reached only by 16-bit pointer moves.
// RULE_06: reset never alters ram contents; this block holds no ram storage.
// RULE_07: lower ram is 00h..7Fh, reachable directly and indirectly.
// RULE_08: bit addresses 00h..7Fh map to bytes 20h..2Fh, bit order ascending.
// RULE_09: lowest 32 bytes form four register banks, one active at a time.
// RULE_10: at 80h and above, indirect reaches upper ram, direct reaches sfr area.
// RULE_11: sfrs with address bits 2..0 zero are bit addressable from 80h.
// RULE_12: extended ram decodes at the top of external data space via external moves.
// RULE_13: with extended ram disabled its range goes to external data memory.
// RULE_14: external space is 64 Kbyte; pointer moves 16-bit, register moves 8-bit.
// RULE_15: a mapped sfr area gets the same direct and bit addressing.
// RULE_16: map select 0 reaches standard sfrs, 1 the mapped area; resets to 0.
// RULE_17: map select is never cleared by hardware, only by software write.
// RULE_18: core registers such as the accumulator decode alike whatever the map select.
// RULE_19: status word bits 3 and 4 form the register bank select code.
// RULE_20: indirect modes take the pointer from register 0 or 1 of the active bank.
// RULE_21: bank code n places the active bank at 8n..8n+7.
// RULE_22: mapped sfr steering only happens on variants implementing the mapped area.
module msdec_decoder #(
    parameter logic [16:0] ROM_BYTES = msdec_pkg::MSDEC_ROM_BYTES,
    parameter bit HAS_MAPPED_SFR = 1'b1,
    parameter bit HAS_ON_CHIP_EXTENDED_RAM = 1'b1
) (
    input wire logic i_clock,
    input wire logic i_resetn,
    input wire logic i_external_access_select,
    input wire logic i_fetch_valid,
    input wire logic [15:0] i_fetch_addr,
    input wire msdec_pkg::msdec_kind_e i_kind,
    input wire logic [15:0] i_addr,
    input wire logic [2:0] i_reg_index,
    input wire logic i_reg_select_one,
    input wire logic [7:0] i_psw,
    input wire logic [7:0] i_pointer_reg,
    input wire logic [15:0] i_data_pointer_16,
    input wire logic i_on_chip_extended_ram_enable,
    input wire logic i_sfr_write,
    input wire logic [7:0] i_sfr_wdata,
    output logic o_fetch_external,
    output logic o_fetch_internal,
    output logic [15:0] o_code_addr,
    output msdec_pkg::msdec_tgt_e o_target,
    output logic [15:0] o_target_addr,
    output logic o_ext_addr_16,
    output logic [2:0] o_bit_index,
    output logic o_bit_access,
    output logic [7:0] o_pointer_ram_addr,
    output logic [1:0] o_active_bank,
    output logic o_register_map_select,
    output logic [7:0] o_system_control
);
    import msdec_pkg::*;

    // ====================================================
    // system control register
    logic [7:0] sysctl_ff;
    logic [7:0] nxt_sysctl;
    wire logic sysctl_hit;
    assign sysctl_hit = (i_kind == MSDEC_ACC_DIRECT) && (i_addr[7:0] == MSDEC_SYSCTL_ADDR);
    // only a software write changes the map select; no hardware clear path
    assign nxt_sysctl = (i_sfr_write && sysctl_hit) ? i_sfr_wdata : sysctl_ff; // RULE_17

    // async reset loads the documented default, map select 0
    always_ff @(posedge i_clock or negedge i_resetn) begin
        if (!i_resetn) begin
            sysctl_ff <= MSDEC_SYSCTL_RESET; // RULE_16
        end else begin
            sysctl_ff <= nxt_sysctl;
        end
    end

    wire logic register_map_select;
    assign register_map_select = sysctl_ff[MSDEC_REGISTER_MAP_SELECT_BIT];

    // ====================================================
    // program fetch steering
    wire logic above_rom;
    wire logic nxt_fetch_ext;
    // compare at 17 bits so a full 64 Kbyte rom never counts as exceeded
    assign above_rom = ({1'b0, i_fetch_addr} >= ROM_BYTES); // RULE_04
    // low select: always external; high: external only past boundary, back on-chip below it
    assign nxt_fetch_ext = !i_external_access_select || above_rom; // RULE_01 RULE_02 RULE_03

    // ====================================================
    // register banks and pointers
    wire logic [1:0] bank;
    assign bank = {i_psw[MSDEC_BANK_HI_BIT], i_psw[MSDEC_BANK_LO_BIT]}; // RULE_19
    wire logic [7:0] reg_ram_addr;
    // bank n occupies 8n..8n+7 within the lowest 32 bytes
    assign reg_ram_addr = {3'b000, bank, i_reg_index}; // RULE_09 RULE_21
    wire logic [7:0] ptr_ram_addr;
    assign ptr_ram_addr = {3'b000, bank, 2'b00, i_reg_select_one}; // RULE_20

    // ====================================================
    // data space decode
    wire logic upper;
    assign upper = (i_addr[7:0] >= MSDEC_UPPER_BASE);
    // bit operands name their byte, so accumulator and status bits also bypass the map
    wire logic [7:0] sfr_byte;
    assign sfr_byte = (i_kind == MSDEC_ACC_BIT) ? {i_addr[7:3], 3'b000} : i_addr[7:0];
    wire logic core_reg;
    // accumulator and status word ignore the map select
    assign core_reg = (sfr_byte == MSDEC_ACC_ADDR) || (sfr_byte == MSDEC_PSW_ADDR); // RULE_18
    wire logic use_mapped;
    // mapped area only exists on variants that build it
    assign use_mapped = HAS_MAPPED_SFR && register_map_select && !core_reg; // RULE_16 RULE_22
    wire msdec_tgt_e sfr_tgt;
    assign sfr_tgt = use_mapped ? MSDEC_TGT_SFR_MAPPED : MSDEC_TGT_SFR_STD; // RULE_15

    // bit address: low half into bytes 20h..2Fh, high half into xxxxx000 sfrs
    wire logic [7:0] bit_byte;
    assign bit_byte = i_addr[7] ? {i_addr[7:3], 3'b000} // RULE_11
                                : (MSDEC_BITRAM_BASE + {4'h0, i_addr[6:3]}); // RULE_08

    // external move address width and extended ram window
    wire logic [15:0] xaddr;
    assign xaddr = (i_kind == MSDEC_ACC_XMOVE_DATA_POINTER_16) ? i_data_pointer_16 : {8'h00, i_pointer_reg}; // RULE_14
    wire logic in_on_chip_extended_ram;
    // decoded at the top of the space; disabled extended ram falls through to external
    assign in_on_chip_extended_ram = HAS_ON_CHIP_EXTENDED_RAM && i_on_chip_extended_ram_enable && (xaddr >= MSDEC_ON_CHIP_EXTENDED_RAM_BASE); // RULE_12 RULE_13

    msdec_tgt_e nxt_target;
    logic [15:0] nxt_taddr;
    logic nxt_ext16;
    logic nxt_bit;

    // steering by address and addressing mode; internal spaces take 8-bit addresses
    always_comb begin
        nxt_target = MSDEC_TGT_NONE;
        nxt_taddr = 16'h0000;
        nxt_ext16 = 1'b0;
        nxt_bit = 1'b0;
        case (i_kind)
            MSDEC_ACC_DIRECT: begin
                nxt_taddr = {8'h00, i_addr[7:0]}; // RULE_05
                nxt_target = upper ? sfr_tgt : MSDEC_TGT_LOWER_RAM; // RULE_07 RULE_10
            end
            MSDEC_ACC_INDIRECT: begin
                nxt_taddr = {8'h00, i_pointer_reg};
                nxt_target = i_pointer_reg[7] ? MSDEC_TGT_UPPER_RAM : MSDEC_TGT_LOWER_RAM; // RULE_10 RULE_07
            end
            MSDEC_ACC_REGISTER: begin
                nxt_taddr = {8'h00, reg_ram_addr};
                nxt_target = MSDEC_TGT_LOWER_RAM; // RULE_09
            end
            MSDEC_ACC_BIT: begin
                nxt_taddr = {8'h00, bit_byte};
                nxt_bit = 1'b1;
                nxt_target = i_addr[7] ? sfr_tgt : MSDEC_TGT_LOWER_RAM; // RULE_15
            end
            MSDEC_ACC_XMOVE_DATA_POINTER_16, MSDEC_ACC_XMOVE_REG: begin
                nxt_taddr = in_on_chip_extended_ram ? (xaddr - MSDEC_ON_CHIP_EXTENDED_RAM_BASE) : xaddr;
                nxt_ext16 = (i_kind == MSDEC_ACC_XMOVE_DATA_POINTER_16); // RULE_14 RULE_05
                nxt_target = in_on_chip_extended_ram ? MSDEC_TGT_ON_CHIP_EXTENDED_RAM : MSDEC_TGT_EXT_DATA;
            end
            default: begin
                nxt_target = MSDEC_TGT_NONE;
            end
        endcase
    end

    // ====================================================
    // registered outputs; no ram storage here, so reset leaves memory contents alone
    msdec_tgt_e target_ff;
    logic [15:0] taddr_ff;
    logic ext16_ff;
    logic bit_ff;
    logic [2:0] bitidx_ff;
    logic fetch_ext_ff;
    logic fetch_int_ff;
    logic [15:0] code_addr_ff;
    logic [7:0] ptr_ff;
    logic [1:0] bank_ff;

    // decode results, one cycle after the request
    always_ff @(posedge i_clock or negedge i_resetn) begin
        if (!i_resetn) begin
            target_ff <= MSDEC_TGT_NONE; // RULE_06
            taddr_ff <= 16'h0000;
            ext16_ff <= 1'b0;
            bit_ff <= 1'b0;
            bitidx_ff <= 3'h0;
        end else begin
            target_ff <= nxt_target;
            taddr_ff <= nxt_taddr;
            ext16_ff <= nxt_ext16;
            bit_ff <= nxt_bit;
            bitidx_ff <= i_addr[2:0];
        end
    end

    // fetch steering and bank state
    always_ff @(posedge i_clock or negedge i_resetn) begin
        if (!i_resetn) begin
            fetch_ext_ff <= 1'b0;
            fetch_int_ff <= 1'b0;
            code_addr_ff <= 16'h0000;
            ptr_ff <= 8'h00;
            bank_ff <= 2'b00;
        end else begin
            fetch_ext_ff <= i_fetch_valid && nxt_fetch_ext; // RULE_01
            fetch_int_ff <= i_fetch_valid && !nxt_fetch_ext; // RULE_02
            code_addr_ff <= i_fetch_addr;
            ptr_ff <= ptr_ram_addr; // RULE_20
            bank_ff <= bank; // RULE_19
        end
    end

    assign o_fetch_external = fetch_ext_ff;
    assign o_fetch_internal = fetch_int_ff;
    assign o_code_addr = code_addr_ff;
    assign o_target = target_ff;
    assign o_target_addr = taddr_ff;
    assign o_ext_addr_16 = ext16_ff;
    assign o_bit_index = bitidx_ff;
    assign o_bit_access = bit_ff;
    assign o_pointer_ram_addr = ptr_ff;
    assign o_active_bank = bank_ff;
    assign o_register_map_select = register_map_select;
    assign o_system_control = sysctl_ff;

endmodule // msdec_decoder

// *** dv/msdec_core_model.sv ***
`timescale 1ns/1ps
// ====================================================
// core side: status word with the bank code in bits 4:3
module msdec_core_model (
    input wire logic [1:0] i_bank,
    output logic [7:0] o_psw
);
    // other flags held at fixed nonzero values (5h above, 3h below) so a decode that reads the wrong bits shows up
    assign o_psw = {3'h5, i_bank, 3'h3};
endmodule // msdec_core_model

// *** dv/msdec_decoder_props.sv ***
`timescale 1ns/1ps
// ====================================================
// decode checker on the top ports
module msdec_decoder_props
    import msdec_pkg::*;
#(
    parameter logic [16:0] ROM_BYTES = MSDEC_ROM_BYTES,
    parameter bit HAS_MAPPED_SFR = 1'b1,
    parameter bit HAS_ON_CHIP_EXTENDED_RAM = 1'b1
) (
    input wire logic i_clock,
    input wire logic i_resetn,
    input wire logic i_external_access_select,
    input wire logic i_fetch_valid,
    input wire logic [15:0] i_fetch_addr,
    input wire msdec_pkg::msdec_kind_e i_kind,
    input wire logic [15:0] i_addr,
    input wire logic [2:0] i_reg_index,
    input wire logic [7:0] i_psw,
    input wire logic [7:0] i_pointer_reg,
    input wire logic [15:0] i_data_pointer_16,
    input wire logic i_on_chip_extended_ram_enable,
    input wire logic i_sfr_write,
    input wire logic o_fetch_external,
    input wire logic o_fetch_internal,
    input wire msdec_pkg::msdec_tgt_e o_target,
    input wire logic [15:0] o_target_addr,
    input wire logic o_ext_addr_16,
    input wire logic [2:0] o_bit_index,
    input wire logic o_register_map_select
);
    default clocking cb @(posedge i_clock); endclocking
    default disable iff (!i_resetn);
    logic [15:0] a_q;
    logic [7:0] p_q;
    logic x_q;
    logic [2:0] r_q;
    // request copies, since outputs answer one edge later
    always_ff @(posedge i_clock) begin
        a_q <= i_addr;
        p_q <= i_psw;
        x_q <= i_on_chip_extended_ram_enable;
        r_q <= i_reg_index;
    end
    // ====================================================
    // properties
    property p_fe; i_fetch_valid && (!i_external_access_select || {1'b0, i_fetch_addr} >= ROM_BYTES)
        |=> o_fetch_external && !o_fetch_internal; endproperty
    a_fe: assert property (p_fe) else $error("fetch not external");
    property p_fi; i_fetch_valid && i_external_access_select && {1'b0, i_fetch_addr} < ROM_BYTES
        |=> o_fetch_internal && !o_fetch_external; endproperty
    a_fi: assert property (p_fi) else $error("fetch not internal");
    property p_lo; i_kind == MSDEC_ACC_DIRECT && !i_addr[7]
        |=> o_target == MSDEC_TGT_LOWER_RAM && o_target_addr == {8'h00, a_q[7:0]}; endproperty
    a_lo: assert property (p_lo) else $error("lower ram decode wrong");
    property p_up; i_kind == MSDEC_ACC_INDIRECT && i_pointer_reg[7] |=> o_target == MSDEC_TGT_UPPER_RAM; endproperty
    a_up: assert property (p_up) else $error("upper ram decode wrong");
    property p_bt; i_kind == MSDEC_ACC_BIT && !i_addr[7] |=> o_bit_index == a_q[2:0]
        && o_target_addr == {8'h00, MSDEC_BITRAM_BASE + {4'h0, a_q[6:3]}}; endproperty
    a_bt: assert property (p_bt) else $error("bit ram decode wrong");
    property p_sb; i_kind == MSDEC_ACC_BIT && i_addr[7] |=> o_target_addr[7:0] == {a_q[7:3], 3'h0}; endproperty
    a_sb: assert property (p_sb) else $error("sfr bit byte wrong");
    property p_mp; i_kind == MSDEC_ACC_DIRECT && i_addr[7] && i_addr[7:0] != MSDEC_ACC_ADDR
        && i_addr[7:0] != MSDEC_PSW_ADDR
        |=> o_target == ((HAS_MAPPED_SFR && $past(o_register_map_select)) ?
        MSDEC_TGT_SFR_MAPPED : MSDEC_TGT_SFR_STD); endproperty
    a_mp: assert property (p_mp) else $error("sfr area choice wrong");
    property p_mb; i_kind == MSDEC_ACC_BIT && i_addr[7] && {i_addr[7:3], 3'h0} != MSDEC_ACC_ADDR
        && {i_addr[7:3], 3'h0} != MSDEC_PSW_ADDR
        |=> o_target == ((HAS_MAPPED_SFR && $past(o_register_map_select)) ?
        MSDEC_TGT_SFR_MAPPED : MSDEC_TGT_SFR_STD); endproperty
    a_mb: assert property (p_mb) else $error("sfr bit area choice wrong");
    property p_cr; (i_kind == MSDEC_ACC_DIRECT && i_addr[7:0] == MSDEC_ACC_ADDR)
        || (i_kind == MSDEC_ACC_BIT && {i_addr[7:3], 3'h0} == MSDEC_ACC_ADDR)
        |=> o_target == MSDEC_TGT_SFR_STD; endproperty
    a_cr: assert property (p_cr) else $error("accumulator followed the map select");
    property p_bk; i_kind == MSDEC_ACC_REGISTER |=> o_target_addr == {11'h000, p_q[4:3], r_q}; endproperty
    a_bk: assert property (p_bk) else $error("register bank address wrong");
    property p_xr; i_kind == MSDEC_ACC_XMOVE_DATA_POINTER_16 && i_data_pointer_16 >= MSDEC_ON_CHIP_EXTENDED_RAM_BASE
        |=> o_target == ((HAS_ON_CHIP_EXTENDED_RAM && x_q) ? MSDEC_TGT_ON_CHIP_EXTENDED_RAM : MSDEC_TGT_EXT_DATA); endproperty
    a_xr: assert property (p_xr) else $error("extended ram steering wrong");
    property p_x8; i_kind == MSDEC_ACC_XMOVE_REG |=> !o_ext_addr_16 && o_target_addr[15:8] == 8'h00; endproperty
    a_x8: assert property (p_x8) else $error("register move not 8-bit");
    property p_hd; !(i_sfr_write && i_kind == MSDEC_ACC_DIRECT && i_addr[7:0] == MSDEC_SYSCTL_ADDR)
        |=> $stable(o_register_map_select); endproperty
    a_hd: assert property (p_hd) else $error("map select changed without write");
endmodule // msdec_decoder_props
bind msdec_decoder msdec_decoder_props #(.ROM_BYTES(ROM_BYTES), .HAS_MAPPED_SFR(HAS_MAPPED_SFR),
    .HAS_ON_CHIP_EXTENDED_RAM(HAS_ON_CHIP_EXTENDED_RAM)) u_props (.i_clock, .i_resetn,
    .i_external_access_select, .i_fetch_valid, .i_fetch_addr, .i_kind, .i_addr, .i_reg_index, .i_psw,
    .i_pointer_reg, .i_data_pointer_16, .i_on_chip_extended_ram_enable, .i_sfr_write, .o_fetch_external, .o_fetch_internal,
    .o_target, .o_target_addr, .o_ext_addr_16, .o_bit_index, .o_register_map_select);

// *** dv/msdec_decoder_bench.sv ***
`timescale 1ns/1ps
// ====================================================
// directed bench: one access per cycle, checked one edge later
module msdec_decoder_bench;
    import msdec_pkg::*;
    logic clk, rstn, ea, fv, rs1, xe, wr, fx, fi, e16, register_map_select, ba;
    logic [15:0] fa, a, ca, ta;
    logic [7:0] wd, processor_status_word, pa, sc;
    logic [2:0] bi;
    logic [1:0] bank, ab;
    msdec_kind_e kd;
    msdec_tgt_e tg;
    int err_count = 0;
    int tests_run = 0;
    msdec_core_model u_core (.i_bank(bank), .o_psw(processor_status_word));
    // pointer, data pointer and register number all follow the access address
    msdec_decoder dut (.i_clock(clk), .i_resetn(rstn), .i_external_access_select(ea), .i_fetch_valid(fv),
        .i_fetch_addr(fa), .i_kind(kd), .i_addr(a), .i_reg_index(a[2:0]), .i_reg_select_one(rs1), .i_psw(processor_status_word),
        .i_pointer_reg(a[7:0]), .i_data_pointer_16(a), .i_on_chip_extended_ram_enable(xe), .i_sfr_write(wr), .i_sfr_wdata(wd),
        .o_fetch_external(fx), .o_fetch_internal(fi), .o_code_addr(ca), .o_target(tg), .o_target_addr(ta),
        .o_ext_addr_16(e16), .o_bit_index(bi), .o_bit_access(ba), .o_pointer_ram_addr(pa), .o_active_bank(ab),
        .o_register_map_select(register_map_select), .o_system_control(sc));
    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end
    // hang guard
    initial begin
        repeat (5000) @(posedge clk);
        err_count++;
        complete_run();
    end
    task complete_run;
        $display("checks %0d errors %0d", tests_run, err_count);
        if (err_count == 0 && tests_run > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    task chk(input logic [15:0] s, input logic [15:0] e);
        tests_run++;
        if (s !== e) begin
            err_count++;
            $display("BAD %0t seen %h want %h", $time, s, e);
        end
    endtask
    task acc(input msdec_kind_e k, input logic [15:0] ad, input msdec_tgt_e t, input logic [15:0] x);
        wr = 1'b0;
        kd = k;
        a = ad;
        @(negedge clk);
        chk(16'(tg), 16'(t));
        chk(ta, x);
    endtask
    task fet(input logic e, input logic [15:0] ad, input logic x);
        fv = 1'b1;
        ea = e;
        fa = ad;
        @(negedge clk);
        chk(16'(fx), 16'(x));
        chk(16'(fi), 16'(!x));
    endtask
    // write strobe stays up until the next plain access lowers it
    task sw(input logic [7:0] ad, input logic [7:0] d);
        kd = MSDEC_ACC_DIRECT;
        a = {8'h00, ad};
        wd = d;
        wr = 1'b1;
        @(negedge clk);
    endtask
    initial begin
        {rstn, ea, fv, rs1, xe, wr, wd, fa, a, bank} = '0;
        kd = MSDEC_ACC_NONE;
        repeat (4) @(negedge clk);
        rstn = 1'b1;
        chk(16'(sc), 16'(MSDEC_SYSCTL_RESET));
        fet(1'b0, 16'h0010, 1'b1);
        chk(ca, 16'h0010);
        fet(1'b1, 16'h1FFF, 1'b0);
        fet(1'b1, 16'h2000, 1'b1);
        fet(1'b1, 16'h1FFE, 1'b0);
        fv = 1'b0;
        acc(MSDEC_ACC_DIRECT, 16'h0045, MSDEC_TGT_LOWER_RAM, 16'h0045);
        chk(16'(ba), 16'h0000);
        acc(MSDEC_ACC_INDIRECT, 16'h007F, MSDEC_TGT_LOWER_RAM, 16'h007F);
        acc(MSDEC_ACC_INDIRECT, 16'h0080, MSDEC_TGT_UPPER_RAM, 16'h0080);
        acc(MSDEC_ACC_DIRECT, 16'h0090, MSDEC_TGT_SFR_STD, 16'h0090);
        acc(MSDEC_ACC_BIT, 16'h0000, MSDEC_TGT_LOWER_RAM, 16'h0020);
        chk(16'(ba), 16'h0001);
        acc(MSDEC_ACC_BIT, 16'h007F, MSDEC_TGT_LOWER_RAM, 16'h002F);
        chk(16'(bi), 16'h0007);
        acc(MSDEC_ACC_BIT, 16'h0085, MSDEC_TGT_SFR_STD, 16'h0080);
        bank = 2'h3;
        acc(MSDEC_ACC_REGISTER, 16'h0005, MSDEC_TGT_LOWER_RAM, 16'h001D);
        chk(16'(ab), 16'h0003);
        bank = 2'h1;
        rs1 = 1'b1;
        acc(MSDEC_ACC_INDIRECT, 16'h0030, MSDEC_TGT_LOWER_RAM, 16'h0030);
        chk(16'(pa), 16'h0009);
        acc(MSDEC_ACC_XMOVE_DATA_POINTER_16, 16'h1234, MSDEC_TGT_EXT_DATA, 16'h1234);
        chk(16'(e16), 16'h0001);
        acc(MSDEC_ACC_XMOVE_REG, 16'hAB55, MSDEC_TGT_EXT_DATA, 16'h0055);
        chk(16'(e16), 16'h0000);
        xe = 1'b1;
        acc(MSDEC_ACC_XMOVE_DATA_POINTER_16, 16'hFF10, MSDEC_TGT_ON_CHIP_EXTENDED_RAM, 16'h0010);
        xe = 1'b0;
        acc(MSDEC_ACC_XMOVE_DATA_POINTER_16, 16'hFF10, MSDEC_TGT_EXT_DATA, 16'hFF10);
        sw(8'hB2, 8'h10);
        sw(MSDEC_SYSCTL_ADDR, 8'h10);
        acc(MSDEC_ACC_DIRECT, 16'h0090, MSDEC_TGT_SFR_MAPPED, 16'h0090);
        chk(16'(sc), 16'h0010);
        acc(MSDEC_ACC_DIRECT, 16'h00E0, MSDEC_TGT_SFR_STD, 16'h00E0);
        acc(MSDEC_ACC_BIT, 16'h0091, MSDEC_TGT_SFR_MAPPED, 16'h0090);
        acc(MSDEC_ACC_BIT, 16'h00E3, MSDEC_TGT_SFR_STD, 16'h00E0);
        kd = MSDEC_ACC_NONE;
        repeat (3) @(negedge clk);
        chk(16'(register_map_select), 16'h0001);
        rstn = 1'b0;
        @(negedge clk);
        rstn = 1'b1;
        chk(16'(sc), 16'(MSDEC_SYSCTL_RESET));
        chk(16'(register_map_select), 16'h0000);
        chk(16'(tg), 16'(MSDEC_TGT_NONE));
        complete_run();
    end
endmodule // msdec_decoder_bench
